// ---- include/backup_charger_pkg.sv ----
/*
 * constants and carrier types for the backup-cell charger control block.
 * assumes a single 10 MHz clock and a plain register port.
 */
package backup_charger_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] CTRL_OFFSET = 8'h1A;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int VSEL_LSB = 0;
    localparam int VSEL_W = 3;
    localparam int EN_BIT = 3;
    localparam logic [7:0] CTRL_WMASK = 8'h0F;
    localparam logic [7:0] STATUS_OFFSET = 8'h1B;

    // ==========================================================
    // charge targets in millivolts, indexed by voltage select
    localparam logic [11:0] MV_0 = 12'h9C4;
    localparam logic [11:0] MV_1 = 12'hA8C;
    localparam logic [11:0] MV_2 = 12'hAF0;
    localparam logic [11:0] MV_3 = 12'hB54;
    localparam logic [11:0] MV_4 = 12'hBB8;
    localparam logic [11:0] MV_5 = 12'hC1C;
    localparam logic [11:0] MV_6 = 12'hC80;
    localparam logic [11:0] MV_7 = 12'hCE4;

    // charge currents in microamps
    localparam logic [6:0] FULL_CURRENT_UA = 7'h3C;
    localparam logic [6:0] REDUCED_CURRENT_UA = 7'h0A;

    // ==========================================================
    // power states and carriers
    typedef enum logic [1:0] {
        PWR_ON,
        PWR_SLEEP,
        PWR_STANDBY,
        PWR_OFF
    } pwr_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic charge_on;
        logic reduced_current;
        logic [6:0] current_ua;
        logic [11:0] target_mv;
    } charge_cmd_t;

endpackage : backup_charger_pkg

// ---- rtl/charge_decode.sv ----
/*
 * combinational charge command decode from control bits, power state and
 * undervoltage. assumes inputs are already synchronous to clk.
 */
module charge_decode (
    input wire logic [2:0] vsel,
    input wire logic enable,
    input wire backup_charger_pkg::pwr_state_t pwr_state,
    input wire logic undervoltage,
    output backup_charger_pkg::charge_cmd_t cmd
);
    import backup_charger_pkg::*;

    // ==========================================================
    // voltage decode
    function automatic logic [11:0] target_mv(input logic [2:0] code);
        case (code)
            3'h0: target_mv = MV_0;
            3'h1: target_mv = MV_1;
            3'h2: target_mv = MV_2;
            3'h3: target_mv = MV_3;
            3'h4: target_mv = MV_4;
            3'h5: target_mv = MV_5;
            3'h6: target_mv = MV_6;
            default: target_mv = MV_7;
        endcase
    endfunction : target_mv

    always_comb begin
        cmd = '0;
        cmd.target_mv = target_mv(vsel);
        // off state and undervoltage veto the enable bit
        cmd.charge_on = enable && (pwr_state != PWR_OFF) && !undervoltage;
        case (pwr_state)
            PWR_ON: begin
                cmd.current_ua = cmd.charge_on ? FULL_CURRENT_UA : 7'h00;
            end
            PWR_SLEEP, PWR_STANDBY: begin
                cmd.reduced_current = cmd.charge_on;
                cmd.current_ua = cmd.charge_on ? REDUCED_CURRENT_UA : 7'h00;
            end
            default: begin
                cmd.current_ua = 7'h00;
            end
        endcase
    end

endmodule : charge_decode

// ---- rtl/backup_charger_control.sv ----
/*
 * backup-cell charger control and always-on supply switchover.
 * assumes power state comes from on-chip sequencing on clk; the analog
 * comparators arrive asynchronously and are synchronised here.
 */
// Strobed register access was decided locally.
// Function
// - 8-bit control at 0x1A: bits 2:0 voltage, bit 3 enable, resets zero.
// - voltage codes 000..111 map to 2.50 through 3.30 volts.
// - charger runs only while the enable bit is set.
// - on state with charging enabled commands full 60 uA current.
// - sleep or standby with charging enabled commands reduced 10 uA current.
// - off state disables charging regardless of enable bit.
// - input undervoltage stops charging in every power state.
// - input below low threshold moves always-on supply to backup pin.
// - supply returns to input only above the higher switchback threshold.
module backup_charger_control (
    input wire logic clk,
    input wire logic arst_n,
    input wire backup_charger_pkg::reg_req_t req,
    output logic [7:0] rdata,
    input wire backup_charger_pkg::pwr_state_t pwr_state,
    input wire logic input_undervoltage_flag,
    input wire logic below_switchover_low_threshold,
    input wire logic above_switchback_high_threshold,
    output backup_charger_pkg::charge_cmd_t charge_cmd,
    output logic supply_from_backup_cell_pin
);
    import backup_charger_pkg::*;

    // ==========================================================
    // reset release
    logic rst_s1_ff;
    logic rst_n_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff <= rst_s1_ff;
        end
    end

    // ==========================================================
    // comparator synchronisers
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= {above_switchback_high_threshold, below_switchover_low_threshold,
                         input_undervoltage_flag};
            sync2_ff <= sync1_ff;
        end
    end
    logic uv_s;
    logic low_s;
    logic high_s;
    assign uv_s = sync2_ff[0];
    assign low_s = sync2_ff[1];
    assign high_s = sync2_ff[2];

    // ==========================================================
    // control register and read port
    logic [7:0] backup_charger_control_ff;
    logic [7:0] nxt_backup_charger_control;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic supply_ff;
    charge_cmd_t charge_cmd_ff;
    always_comb begin
        nxt_backup_charger_control = backup_charger_control_ff;
        if (req.wr && req.addr == CTRL_OFFSET) begin
            nxt_backup_charger_control = req.wdata & CTRL_WMASK;
        end
        nxt_rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                CTRL_OFFSET: nxt_rdata = backup_charger_control_ff & CTRL_WMASK;
                STATUS_OFFSET: nxt_rdata = {5'h00, supply_ff, charge_cmd_ff.reduced_current,
                                            charge_cmd_ff.charge_on};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            backup_charger_control_ff <= CTRL_RESET;
            rdata_ff <= 8'h00;
        end else begin
            backup_charger_control_ff <= nxt_backup_charger_control;
            rdata_ff <= nxt_rdata;
        end
    end
    assign rdata = rdata_ff;

    // ==========================================================
    // charge command; registered so outputs come from flops
    charge_cmd_t cmd_comb;
    charge_cmd_t nxt_charge_cmd;
    charge_decode u_decode (
        .vsel(backup_charger_control_ff[VSEL_LSB +: VSEL_W]),
        .enable(backup_charger_control_ff[EN_BIT]),
        .pwr_state(pwr_state),
        .undervoltage(uv_s),
        .cmd(cmd_comb)
    );
    always_comb begin
        nxt_charge_cmd = cmd_comb;
    end
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            charge_cmd_ff <= '0;
        end else begin
            charge_cmd_ff <= nxt_charge_cmd;
        end
    end
    assign charge_cmd = charge_cmd_ff;

    // ==========================================================
    // supply switchover with hysteresis; starts on the input supply
    logic nxt_supply;
    // low wins when both comparators read high, so a noisy input falls back to the cell
    always_comb begin
        nxt_supply = supply_ff;
        if (low_s) begin
            nxt_supply = 1'b1;
        end else if (high_s) begin
            nxt_supply = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            supply_ff <= 1'b0;
        end else begin
            supply_ff <= nxt_supply;
        end
    end
    assign supply_from_backup_cell_pin = supply_ff;

    // ==========================================================
    // checks
    a_upper_bits_zero: assert property (@(posedge clk) disable iff (!rst_n_ff)
        req.rd && req.addr == CTRL_OFFSET |=> rdata[7:4] == 4'h0)
        else $error("upper control bits read nonzero");
    a_write_stores: assert property (@(posedge clk) disable iff (!rst_n_ff)
        req.wr && req.addr == CTRL_OFFSET |=> backup_charger_control_ff == (
        $past(req.wdata) & CTRL_WMASK))
        else $error("control write not stored");
    a_enable_gates: assert property (@(posedge clk) disable iff (!rst_n_ff)
        !backup_charger_control_ff[EN_BIT] |=> !charge_cmd.charge_on)
        else $error("charging without enable");
    a_full_current: assert property (@(posedge clk) disable iff (!rst_n_ff)
        backup_charger_control_ff[EN_BIT] && pwr_state == PWR_ON && !uv_s
        |=> charge_cmd.current_ua == FULL_CURRENT_UA)
        else $error("full current missing in on state");
    a_reduced_current: assert property (@(posedge clk) disable iff (!rst_n_ff)
        backup_charger_control_ff[EN_BIT] && pwr_state inside {PWR_SLEEP, PWR_STANDBY} && !uv_s
        |=> charge_cmd.current_ua == REDUCED_CURRENT_UA)
        else $error("reduced current missing");
    a_off_blocks: assert property (@(posedge clk) disable iff (!rst_n_ff)
        pwr_state == PWR_OFF |=> !charge_cmd.charge_on && charge_cmd.current_ua == 7'h00)
        else $error("charging in off state");
    a_uv_blocks: assert property (@(posedge clk) disable iff (!rst_n_ff)
        uv_s |=> !charge_cmd.charge_on)
        else $error("charging under undervoltage");
    a_switch_over: assert property (@(posedge clk) disable iff (!rst_n_ff)
        low_s |=> supply_from_backup_cell_pin)
        else $error("no switchover below low threshold");
    a_switch_hold: assert property (@(posedge clk) disable iff (!rst_n_ff)
        supply_from_backup_cell_pin && !high_s |=> supply_from_backup_cell_pin)
        else $error("switched back without high threshold");
    a_target_top: assert property (@(posedge clk) disable iff (!rst_n_ff)
        backup_charger_control_ff[2:0] == 3'h7 |=> charge_cmd.target_mv == MV_7)
        else $error("target decode wrong");
    a_target_low: assert property (@(posedge clk) disable iff (!rst_n_ff)
        backup_charger_control_ff[VSEL_LSB +: VSEL_W] == 3'h0
        |=> charge_cmd.target_mv == MV_0)
        else $error("target decode wrong for lowest code");
    a_sleep_flag: assert property (@(posedge clk) disable iff (!rst_n_ff)
        backup_charger_control_ff[EN_BIT] && pwr_state inside {PWR_SLEEP, PWR_STANDBY} && !uv_s
        |=> charge_cmd.reduced_current)
        else $error("reduced current flag missing");
    a_idle_no_current: assert property (@(posedge clk) disable iff (!rst_n_ff)
        !charge_cmd.charge_on |-> charge_cmd.current_ua == 7'h00)
        else $error("current commanded while charger off");
    a_switch_back: assert property (@(posedge clk) disable iff (!rst_n_ff)
        !low_s && high_s |=> !supply_from_backup_cell_pin)
        else $error("no switchback above high threshold");
    // read data drops to zero so a stale byte never looks like a fresh read
    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n_ff)
        !req.rd |=> rdata == 8'h00)
        else $error("read data without a read");
    a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n_ff)
        req.rd && req.addr != CTRL_OFFSET && req.addr != STATUS_OFFSET
        |=> rdata == 8'h00)
        else $error("unmapped read returned data");
    a_ctrl_hold: assert property (@(posedge clk) disable iff (!rst_n_ff)
        !(req.wr && req.addr == CTRL_OFFSET) |=> $stable(backup_charger_control_ff))
        else $error("control changed without a write");
    a_status_read: assert property (@(posedge clk) disable iff (!rst_n_ff)
        req.rd && req.addr == STATUS_OFFSET |=> rdata == {5'h00,
        $past(supply_from_backup_cell_pin), $past(charge_cmd.reduced_current),
        $past(charge_cmd.charge_on)})
        else $error("status read wrong");

    // ==========================================================
    // cover points
    c_charge_on: cover property (@(posedge clk) disable iff (!rst_n_ff) charge_cmd.charge_on);
    c_reduced: cover property (@(posedge clk) disable iff (!rst_n_ff)
        charge_cmd.reduced_current);
    c_switch: cover property (@(posedge clk) disable iff (!rst_n_ff)
        $fell(supply_from_backup_cell_pin));
    c_status_read: cover property (@(posedge clk) disable iff (!rst_n_ff)
        req.rd && req.addr == STATUS_OFFSET);
    c_off_enabled: cover property (@(posedge clk) disable iff (!rst_n_ff)
        backup_charger_control_ff[EN_BIT] && pwr_state == PWR_OFF);

endmodule : backup_charger_control

// ---- bench/backup_charger_control_tb.sv ----
/*
 * self-checking bench for backup_charger_control: register port, charge command
 * decode and supply switchover.
 * assumes the package types, a 10 MHz clock and registered outputs.
 */
module backup_charger_control_tb import backup_charger_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // signals and design
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    reg_req_t req = '0;
    logic [7:0] rdata;
    pwr_state_t pwr_state = PWR_ON;
    logic uv = 1'b0;
    logic below = 1'b0;
    logic above = 1'b1;
    charge_cmd_t charge_cmd;
    logic supply;
    int fail_count = 0;
    int n_checks = 0;
    logic [11:0] mv_tab [8] = '{MV_0, MV_1, MV_2, MV_3, MV_4, MV_5, MV_6, MV_7};

    always #50 clk = ~clk;

    backup_charger_control u_backup_charger_control (
        .clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .pwr_state(pwr_state),
        .input_undervoltage_flag(uv), .below_switchover_low_threshold(below),
        .above_switchback_high_threshold(above), .charge_cmd(charge_cmd),
        .supply_from_backup_cell_pin(supply)
    );

    // ==========================================================
    // helpers
    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    // outputs are sampled 1 ns after the edge so the edge's updates have landed
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // ==========================================================
    // scenarios
    task automatic t_register();
        logic [7:0] d;
        rd(CTRL_OFFSET, d);
        chk_val(d, 12'h000);
        chk_val({11'h000, charge_cmd.charge_on}, 12'h000);
        wr(CTRL_OFFSET, 8'hFF);
        rd(CTRL_OFFSET, d);
        chk_val(d, 12'h00F);
        wr(8'h20, 8'h05);
        rd(CTRL_OFFSET, d);
        chk_val(d, 12'h00F);
        rd(8'h20, d);
        chk_val(d, 12'h000);
    endtask : t_register

    task automatic t_voltage();
        for (int v = 0; v < 8; v++) begin
            wr(CTRL_OFFSET, 8'h08 | 8'(v));
            step(4);
            chk_val(charge_cmd.target_mv, mv_tab[v]);
        end
    endtask : t_voltage

    task automatic t_power();
        logic on;
        for (int e = 0; e < 2; e++) begin
            for (int s = 0; s < 4; s++) begin
                wr(CTRL_OFFSET, (e != 0) ? 8'h0B : 8'h03);
                @(posedge clk);
                pwr_state <= pwr_state_t'(s);
                step(4);
                on = (e != 0) && (s != 3);
                chk_val({11'h000, charge_cmd.charge_on}, {11'h000, on});
                chk_val({5'h00, charge_cmd.current_ua},
                        !on ? 12'h000 : (s == 0) ? 12'h03C : 12'h00A);
                if (on) chk_val({11'h000, charge_cmd.reduced_current}, 12'(s != 0));
            end
        end
        @(posedge clk);
        pwr_state <= PWR_ON;
        step(4);
        @(posedge clk);
        pwr_state <= PWR_SLEEP;
        step(1);
        chk_val({5'h00, charge_cmd.current_ua}, 12'h00A);
    endtask : t_power

    task automatic t_uv();
        for (int s = 0; s < 3; s++) begin
            @(posedge clk);
            pwr_state <= pwr_state_t'(s);
            uv <= 1'b1;
            step(5);
            chk_val({11'h000, charge_cmd.charge_on}, 12'h000);
            @(posedge clk);
            uv <= 1'b0;
            step(5);
            chk_val({11'h000, charge_cmd.charge_on}, 12'h001);
        end
    endtask : t_uv

    task automatic t_switch();
        logic [7:0] d;
        chk_val({11'h000, supply}, 12'h000);
        @(posedge clk);
        below <= 1'b1;
        above <= 1'b0;
        step(5);
        chk_val({11'h000, supply}, 12'h001);
        rd(STATUS_OFFSET, d);
        chk_val({4'h0, d}, 12'h007);
        @(posedge clk);
        below <= 1'b0;
        step(5);
        chk_val({11'h000, supply}, 12'h001);
        @(posedge clk);
        above <= 1'b1;
        step(5);
        chk_val({11'h000, supply}, 12'h000);
        rd(STATUS_OFFSET, d);
        chk_val({4'h0, d}, 12'h003);
        @(posedge clk);
        below <= 1'b1;
        step(5);
        chk_val({11'h000, supply}, 12'h001);
    endtask : t_switch

    // reset in mid-run clears the control register; switchover follows the pins again
    task automatic t_reset();
        logic [7:0] d;
        @(posedge clk);
        arst_n <= 1'b0;
        step(2);
        chk_val({11'h000, charge_cmd.charge_on}, 12'h000);
        @(posedge clk);
        arst_n <= 1'b1;
        step(3);
        rd(CTRL_OFFSET, d);
        chk_val({4'h0, d}, 12'h000);
        chk_val({11'h000, charge_cmd.charge_on}, 12'h000);
        chk_val({11'h000, supply}, 12'h001);
    endtask : t_reset

    // ==========================================================
    // run control
    task automatic end_sim();
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // the tests need well under 1000 cycles; the limit leaves ample margin
    initial begin
        #400000;
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_register();
        t_voltage();
        t_power();
        t_uv();
        t_switch();
        t_reset();
        end_sim();
    end

endmodule : backup_charger_control_tb
